/* hdl/ditd_pkg.sv */
/*
 package of the trigger and data path block: register offsets, field
 positions, reset values, encodings and timing constants.
 assumes a word-aligned register port with byte addresses.
*/
package ditd_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_TRIG_CTRL = 8'h00;
   localparam logic [7:0] OFS_SOFT_TRIG = 8'h04;
   localparam logic [7:0] OFS_AND_MASK = 8'h08;
   localparam logic [7:0] OFS_DELAY_CAPT = 8'h0C;
   localparam logic [7:0] OFS_DELAY_STIM = 8'h10;
   localparam logic [7:0] OFS_DELAY_DUT = 8'h14;
   localparam logic [7:0] OFS_SERIAL_BITS = 8'h18;
   localparam logic [7:0] OFS_DIRECT_IO = 8'h1C;
   localparam logic [7:0] OFS_IO_MODE = 8'h20;
   localparam logic [7:0] OFS_MEM_DATA = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_SAMPLE = 8'h2C;
   // ==========================================================
   // field positions
   localparam int TC_SEL_LSB = 0;
   localparam int TC_PXI_LOW = 3;
   localparam int TC_HIGH_SPEED = 4;
   localparam int TC_MEAS = 5;
   localparam int IOM_DIR = 0;
   localparam int IOM_MODE_LSB = 1;
   localparam int ST_RUN = 0;
   localparam int ST_SOFT = 1;
   localparam int ST_CNT_LSB = 8;
   // ==========================================================
   // reset values and limits
   localparam logic [23:0] MASK_RESET = 24'hFFFFFF;
   localparam logic [4:0] BITS_RESET = 5'h08;
   localparam logic [4:0] BITS_MIN = 5'h01;
   localparam logic [4:0] BITS_MAX = 5'h18;
   localparam logic [3:0] REV_SPLIT_LO = 4'h5;
   localparam logic [3:0] REV_SPLIT_HI = 4'h9;
   // ==========================================================
   // delay line timing
   localparam int DELAY_MAX_PS = 18420;
   localparam int DELAY_STEP_PS = 10;
   localparam logic [10:0] DELAY_MAX_CODE = 11'(DELAY_MAX_PS / DELAY_STEP_PS);
   // ==========================================================
   // encodings
   typedef enum logic [2:0] {
      TS_SOFT = 3'h0,
      TS_FRONT = 3'h1,
      TS_CODE2 = 3'h2,
      TS_CODE3 = 3'h3,
      TS_CODE4 = 3'h4
   } ditd_trig_t;
   typedef enum logic [2:0] {
      DM_PARALLEL = 3'h0,
      DM_SER_MSB = 3'h1,
      DM_SER_LSB = 3'h2,
      DM_BYTE_MUX = 3'h3,
      DM_BYTE_SPLIT = 3'h4
   } ditd_mode_t;
   typedef enum logic [1:0] {
      LK_IDLE = 2'h0,
      LK_GATHER = 2'h1,
      LK_WAIT = 2'h2
   } ditd_link_t;
endpackage

/* hdl/ditd_core.sv */
/*
 trigger selection, and mask, clock delay settings, direct i/o and
 the pattern data path of the pattern i/o module.
 assumes a register port on clk_in with read data one cycle later,
 and a link clock from the pattern side on link_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ditd_core
   import ditd_pkg::*;
#(
   parameter int DATA_W = 24,
   parameter logic [3:0] LOGIC_REV = 4'h9
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic link_clk_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // trigger pins
   input wire logic front_trig_in,
   input wire logic cable_trigger_zero_in,
   input wire logic cable_trigger_one_in,
   input wire logic pxi_trig_in,
   // pattern clocks and delay lines
   output logic capt_clk_en_out,
   output logic stim_clk_en_out,
   output logic [10:0] delay_capt_out,
   output logic [10:0] delay_stim_out,
   output logic [10:0] delay_dut_out,
   // pattern memory
   output logic mem_wr_out,
   output logic [DATA_W-1:0] mem_wdata_out,
   input wire logic [DATA_W-1:0] mem_rdata_in,
   // data pins
   input wire logic [DATA_W-1:0] dio_in,
   output logic [DATA_W-1:0] dio_out,
   output logic [DATA_W-1:0] dio_oe_out
);
   // ==========================================================
   // helpers
   function automatic logic [10:0] clip_delay(input logic [31:0] v);
      clip_delay = (v > 32'(DELAY_MAX_CODE)) ? DELAY_MAX_CODE : v[10:0];
   endfunction

   function automatic logic pick_trig(input logic [2:0] sel, input logic hs,
      input logic pxl, input logic fr, input logic c0, input logic c1, input logic px);
      logic hit;
      hit = 1'b0;
      if (LOGIC_REV >= REV_SPLIT_HI) begin
         case (sel)
            TS_FRONT: hit = fr;
            TS_CODE2: hit = hs ? c0 : c1;
            TS_CODE3: hit = hs ? ~c1 : (px ^ pxl);
            TS_CODE4: hit = hs & (px ^ pxl);
            default: hit = 1'b0;
         endcase
      end else begin
         case (sel)
            TS_FRONT: hit = (LOGIC_REV >= REV_SPLIT_LO) ? fr : ~fr;
            TS_CODE2: hit = c0;
            TS_CODE3: hit = ~c1;
            default: hit = 1'b0;
         endcase
      end
      pick_trig = hit;
   endfunction

   // ==========================================================
   // registers
   logic [2:0] trig_sel;
   logic pxi_low, high_speed, meas_mode, soft_pend, running;
   logic [23:0] and_mask;
   logic [10:0] dly_capt, dly_stim, dly_dut;
   logic [4:0] bit_count;
   logic [DATA_W-1:0] direct_val, sample_word;
   logic dir_out;
   logic [2:0] data_mode;
   logic [15:0] sample_cnt;
   logic [3:0] trig_s1, trig_s2;
   logic [DATA_W-1:0] pin_s1, pin_s2;

   wire [DATA_W-1:0] mask_w = DATA_W'(and_mask);
   wire wr_ctrl = wr_in && (addr_in == OFS_TRIG_CTRL);
   wire wr_soft = wr_in && (addr_in == OFS_SOFT_TRIG);
   wire wr_mask = wr_in && (addr_in == OFS_AND_MASK);
   wire wr_dc = wr_in && (addr_in == OFS_DELAY_CAPT);
   wire wr_ds = wr_in && (addr_in == OFS_DELAY_STIM);
   wire wr_dd = wr_in && (addr_in == OFS_DELAY_DUT);
   wire wr_bits = wr_in && (addr_in == OFS_SERIAL_BITS);
   wire wr_dio = wr_in && (addr_in == OFS_DIRECT_IO);
   wire wr_iom = wr_in && (addr_in == OFS_IO_MODE);
   wire wr_mem = wr_in && (addr_in == OFS_MEM_DATA);

   // ==========================================================
   // trigger pins and run control
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_s1 <= 4'h0;
         trig_s2 <= 4'h0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         trig_s1 <= {pxi_trig_in, cable_trigger_one_in, cable_trigger_zero_in, front_trig_in};
         trig_s2 <= trig_s1;
         pin_s1 <= dio_in;
         pin_s2 <= pin_s1;
      end
   end

   wire ext_hit = pick_trig(trig_sel, high_speed, pxi_low, trig_s2[0], trig_s2[1],
      trig_s2[2], trig_s2[3]);
   wire trig_hit = (trig_sel == TS_SOFT) ? soft_pend : ext_hit;
   wire next_running = meas_mode && (running || trig_hit);
   wire run_start = next_running && !running;
   // set by a write wins over the clear by a run start
   wire next_soft = (wr_soft && wdata_in[0]) ? 1'b1 :
      ((wr_soft || run_start) ? 1'b0 : soft_pend);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_sel <= 3'h0;
         pxi_low <= 1'b0;
         high_speed <= 1'b0;
         meas_mode <= 1'b0;
         soft_pend <= 1'b0;
         running <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            trig_sel <= wdata_in[TC_SEL_LSB +: 3];
            pxi_low <= wdata_in[TC_PXI_LOW];
            high_speed <= wdata_in[TC_HIGH_SPEED];
            meas_mode <= wdata_in[TC_MEAS];
         end
         soft_pend <= next_soft;
         running <= next_running;
      end
   end

   // ==========================================================
   // settings
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         and_mask <= MASK_RESET;
         dly_capt <= 11'h000;
         dly_stim <= 11'h000;
         dly_dut <= 11'h000;
         bit_count <= BITS_RESET;
         direct_val <= '0;
         dir_out <= 1'b0;
         data_mode <= DM_PARALLEL;
      end else begin
         if (wr_mask) and_mask <= wdata_in[23:0];
         if (wr_dc) dly_capt <= clip_delay(wdata_in);
         if (wr_ds) dly_stim <= clip_delay(wdata_in);
         if (wr_dd) dly_dut <= clip_delay(wdata_in);
         if (wr_bits) begin
            if (wdata_in > 32'(BITS_MAX)) bit_count <= BITS_MAX;
            else if (wdata_in[4:0] < BITS_MIN) bit_count <= BITS_MIN;
            else bit_count <= wdata_in[4:0];
         end
         if (wr_dio && dir_out) direct_val <= wdata_in[DATA_W-1:0];
         if (wr_iom) begin
            dir_out <= wdata_in[IOM_DIR];
            data_mode <= wdata_in[IOM_MODE_LSB +: 3];
         end
      end
   end

   // ==========================================================
   // link crossing, clock side
   logic [2:0] req_sync;
   logic ack_tgl;
   logic lk_req;
   logic [DATA_W-1:0] link_hold;
   wire word_arrived = req_sync[2] ^ req_sync[1];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_sync <= 3'h0;
         ack_tgl <= 1'b0;
         sample_word <= '0;
         sample_cnt <= 16'h0000;
      end else begin
         req_sync <= {req_sync[1:0], 1'b0} | {2'b00, lk_req};
         if (word_arrived) begin
            ack_tgl <= ~ack_tgl;
            sample_word <= link_hold & mask_w;
            sample_cnt <= sample_cnt + 16'h0001;
         end
      end
   end

   // ==========================================================
   // memory, pins and outputs
   wire cap_store = word_arrived && running;
   wire [DATA_W-1:0] next_mem_wdata = wr_mem ? (wdata_in[DATA_W-1:0] & mask_w)
      : (link_hold & mask_w);
   wire meas_split = meas_mode && (data_mode == DM_BYTE_SPLIT);
   wire [DATA_W-1:0] next_oe = (dir_out && !meas_split) ? '1 : '0;
   wire [DATA_W-1:0] io_read = dir_out ? direct_val : pin_s2;
   wire [31:0] status_w = {8'h00, sample_cnt, 6'h00, soft_pend, running};

   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (addr_in)
         OFS_TRIG_CTRL: next_rdata = {26'h0, meas_mode, high_speed, pxi_low, trig_sel};
         OFS_SOFT_TRIG: next_rdata = {31'h0, soft_pend};
         OFS_AND_MASK: next_rdata = {8'h00, and_mask};
         OFS_DELAY_CAPT: next_rdata = {21'h0, dly_capt};
         OFS_DELAY_STIM: next_rdata = {21'h0, dly_stim};
         OFS_DELAY_DUT: next_rdata = {21'h0, dly_dut};
         OFS_SERIAL_BITS: next_rdata = {27'h0, bit_count};
         OFS_DIRECT_IO: next_rdata = 32'(io_read);
         OFS_IO_MODE: next_rdata = {28'h0, data_mode, dir_out};
         OFS_MEM_DATA: next_rdata = 32'(mem_rdata_in & mask_w);
         OFS_STATUS: next_rdata = status_w;
         OFS_SAMPLE: next_rdata = 32'(sample_word);
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= 32'h0000_0000;
         capt_clk_en_out <= 1'b0;
         stim_clk_en_out <= 1'b0;
         delay_capt_out <= 11'h000;
         delay_stim_out <= 11'h000;
         delay_dut_out <= 11'h000;
         mem_wr_out <= 1'b0;
         mem_wdata_out <= '0;
         dio_out <= '0;
         dio_oe_out <= '0;
      end else begin
         rdata_out <= rd_in ? next_rdata : 32'h0000_0000;
         capt_clk_en_out <= next_running;
         stim_clk_en_out <= next_running;
         delay_capt_out <= dly_capt;
         delay_stim_out <= dly_stim;
         delay_dut_out <= dly_dut;
         mem_wr_out <= wr_mem || cap_store;
         mem_wdata_out <= next_mem_wdata;
         dio_out <= direct_val;
         dio_oe_out <= next_oe;
      end
   end

   // ==========================================================
   // link side: sample assembly
   logic [1:0] run_l;
   logic [2:0] mode_l1, mode_l2;
   logic [4:0] bits_l1, bits_l2;
   logic [DATA_W-1:0] lpin1, lpin2, shreg;
   logic [4:0] shcnt;
   logic [1:0] ack_l;
   logic byte_hi;
   ditd_link_t lk_state;

   wire ser_bit = lpin2[0];
   wire [DATA_W-1:0] sh_msb = {shreg[DATA_W-2:0], ser_bit};
   wire [DATA_W-1:0] sh_lsb = {ser_bit, shreg[DATA_W-1:1]};
   wire ser_last = (shcnt == bits_l2 - 5'h01);
   wire [DATA_W-1:0] lsb_word = sh_lsb >> (5'(DATA_W) - bits_l2);
   wire [DATA_W-1:0] msb_word = sh_msb & ((DATA_W'(1) << bits_l2) - DATA_W'(1));

   logic word_done;
   logic [DATA_W-1:0] word_val;
   always_comb begin
      word_done = 1'b0;
      word_val = lpin2;
      case (mode_l2)
         DM_PARALLEL: word_done = 1'b1;
         DM_SER_MSB: begin
            word_done = ser_last;
            word_val = msb_word;
         end
         DM_SER_LSB: begin
            word_done = ser_last;
            word_val = lsb_word;
         end
         DM_BYTE_MUX: begin
            word_done = byte_hi;
            word_val = DATA_W'({lpin2[7:0], shreg[7:0]});
         end
         DM_BYTE_SPLIT: begin
            word_done = 1'b1;
            word_val = DATA_W'(lpin2[15:0]);
         end
         default: word_done = 1'b1;
      endcase
   end

   always_ff @(posedge link_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         run_l <= 2'h0;
         mode_l1 <= 3'h0;
         mode_l2 <= 3'h0;
         bits_l1 <= BITS_RESET;
         bits_l2 <= BITS_RESET;
         lpin1 <= '0;
         lpin2 <= '0;
         ack_l <= 2'h0;
      end else begin
         run_l <= {run_l[0], running};
         mode_l1 <= data_mode;
         mode_l2 <= mode_l1;
         bits_l1 <= bit_count;
         bits_l2 <= bits_l1;
         lpin1 <= dio_in;
         lpin2 <= lpin1;
         ack_l <= {ack_l[0], ack_tgl};
      end
   end

   always_ff @(posedge link_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lk_state <= LK_IDLE;
         shreg <= '0;
         shcnt <= 5'h00;
         byte_hi <= 1'b0;
         lk_req <= 1'b0;
         link_hold <= '0;
      end else begin
         case (lk_state)
            LK_IDLE: begin
               shcnt <= 5'h00;
               byte_hi <= 1'b0;
               if (run_l[1]) lk_state <= LK_GATHER;
            end
            LK_GATHER: begin
               shreg <= (mode_l2 == DM_SER_LSB) ? sh_lsb :
                  ((mode_l2 == DM_BYTE_MUX) ? lpin2 : sh_msb);
               shcnt <= word_done ? 5'h00 : shcnt + 5'h01;
               byte_hi <= ~byte_hi && (mode_l2 == DM_BYTE_MUX);
               if (!run_l[1]) lk_state <= LK_IDLE;
               else if (word_done) begin
                  link_hold <= word_val;
                  lk_req <= ~lk_req;
                  lk_state <= LK_WAIT;
               end
            end
            LK_WAIT: begin
               if (ack_l[1] == lk_req) lk_state <= run_l[1] ? LK_GATHER : LK_IDLE;
            end
            default: lk_state <= LK_IDLE;
         endcase
      end
   end
endmodule // ditd_core
`default_nettype wire

/* bench/ditd_core_chk_sva.sv */
/*
 checker for the trigger and data path block: port level assertions.
 assumes it is bound to ditd_core and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module ditd_core_chk
   import ditd_pkg::*;
#(
   parameter int DATA_W = 24
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // run and delays
   input wire logic capt_clk_en_out,
   input wire logic stim_clk_en_out,
   input wire logic [10:0] delay_stim_out,
   // memory and pins
   input wire logic mem_wr_out,
   input wire logic [DATA_W-1:0] mem_wdata_out,
   input wire logic [DATA_W-1:0] mem_rdata_in,
   input wire logic [DATA_W-1:0] dio_out,
   input wire logic [DATA_W-1:0] dio_oe_out
);
   // ==========================================================
   // shadow of the settings
   logic [DATA_W-1:0] mask_q;
   logic [5:0] tc_q;
   logic dir_q;
   wire logic soft_go;
   assign soft_go = wr_in && addr_in == OFS_SOFT_TRIG && wdata_in[0] && tc_q[TC_MEAS]
      && tc_q[2:0] == 3'h0;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mask_q <= MASK_RESET;
         tc_q <= 6'h00;
         dir_q <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == OFS_AND_MASK) mask_q <= wdata_in[DATA_W-1:0];
         if (addr_in == OFS_TRIG_CTRL) tc_q <= wdata_in[5:0];
         if (addr_in == OFS_IO_MODE) dir_q <= wdata_in[IOM_DIR];
      end
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   a_mask_read: assert property (rd_in && addr_in == OFS_AND_MASK
      |=> rdata_out == {8'h00, mask_q}) else $error("mask readback wrong");
   a_wdata_masked: assert property (wr_in && addr_in == OFS_MEM_DATA
      |=> mem_wr_out && mem_wdata_out == ($past(wdata_in[DATA_W-1:0]) & mask_q))
      else $error("memory write not masked");
   a_rdata_masked: assert property (rd_in && addr_in == OFS_MEM_DATA
      |=> rdata_out == {8'h00, $past(mem_rdata_in) & mask_q}) else $error("memory read not masked");
   a_soft_start: assert property (soft_go |-> ##2 capt_clk_en_out)
      else $error("soft trigger did not start run");
   a_idle_stop: assert property (!tc_q[TC_MEAS] |=> !capt_clk_en_out)
      else $error("clocks run outside measurement");
   a_clk_pair: assert property (capt_clk_en_out == stim_clk_en_out)
      else $error("capture and stimulus enables differ");
   a_delay_load: assert property (wr_in && addr_in == OFS_DELAY_STIM && wdata_in <= 32'h732
      |-> ##2 delay_stim_out == $past(wdata_in[10:0], 2)) else $error("delay code not loaded");
   a_io_hold: assert property (wr_in && addr_in == OFS_DIRECT_IO && !dir_q
      |-> ##2 $stable(dio_out)) else $error("direct write taken while input");
   a_oe_dir: assert property ($stable(dir_q) && $stable(tc_q[TC_MEAS]) && !tc_q[TC_MEAS]
      |-> dio_oe_out == {DATA_W{dir_q}}) else $error("pin drive disagrees with direction");
   c_soft_run: cover property (soft_go ##2 capt_clk_en_out);
   c_mem_write: cover property (mem_wr_out);
   c_drive: cover property (dio_oe_out != '0);
endmodule // ditd_core_chk
`default_nettype wire

/* bench/ditd_adc_model.sv */
/*
 converter model on the pattern side: link clock and data pins.
 assumes run_in is high while a frame runs or reset is applied.
*/
`timescale 1ns/1ps
`default_nettype none
module ditd_adc_model (
   // control
   input wire logic run_in,
   input wire logic [23:0] word_in,
   // link side
   output logic lclk_out,
   output logic [23:0] pins_out
);
   // ==========================================================
   // link clock stands still between frames
   initial lclk_out = 1'b0;
   always begin
      #16;
      lclk_out = run_in ? ~lclk_out : 1'b0;
   end
   // converter result held on the pins
   assign pins_out = word_in;
endmodule // ditd_adc_model
`default_nettype wire

/* bench/ditd_core_tb_top.sv */
/*
 testbench for the trigger and data path block.
 assumes the package offsets and the converter model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module ditd_core_tb_top
   import ditd_pkg::*;
;
   // ==========================================================
   // signals
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [3:0] trig = 4'h0;
   logic [23:0] mem_rdata_in = 24'h123456;
   logic [23:0] word = 24'h00C3A5;
   logic [31:0] rdata_out;
   logic capt_en, stim_en, mem_wr_out, link_clk;
   logic [10:0] d_capt, d_stim, d_dut;
   logic [23:0] mem_wdata_out, dio_out, dio_oe_out, pins, dio_in;
   logic [31:0] d;
   int fails = 0;
   int n_checks = 0;
   logic [7:0] tcs [9] = '{8'h21, 8'h22, 8'h23, 8'h2B, 8'h31, 8'h32, 8'h33, 8'h34, 8'h3C};
   logic [1:0] pin [9] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   logic act [9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [31:0] smp [5] = '{32'hC305, 32'hF, 32'hF, 32'hA505, 32'hC305};
   always #10 clk_in = ~clk_in;
   assign dio_in = (dio_out & dio_oe_out) | (pins & ~dio_oe_out);
   ditd_adc_model i_adc (.run_in(capt_en | ~rst_b_in), .word_in(word), .lclk_out(link_clk),
      .pins_out(pins));
   ditd_core i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .front_trig_in(trig[0]), .cable_trigger_zero_in(trig[1]),
      .cable_trigger_one_in(trig[2]), .pxi_trig_in(trig[3]), .capt_clk_en_out(capt_en),
      .stim_clk_en_out(stim_en), .delay_capt_out(d_capt), .delay_stim_out(d_stim),
      .delay_dut_out(d_dut), .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
      .mem_rdata_in(mem_rdata_in), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_out(dio_oe_out));
   // ==========================================================
   // bus and compare tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(nm, rdata_out, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rchk("mask", OFS_AND_MASK, 32'h00FFFFFF);
      rchk("bits", OFS_SERIAL_BITS, 32'h8);
      rchk("soft", OFS_SOFT_TRIG, 32'h0);
      chk("oe", {8'h0, dio_oe_out}, 32'h0);
      wr(OFS_TRIG_CTRL, 32'h20);
      cyc(4);
      chk("idle", {31'h0, capt_en}, 32'h0);
      wr(OFS_SOFT_TRIG, 32'h1);
      cyc(3);
      chk("run", {30'h0, capt_en, stim_en}, 32'h3);
      wr(OFS_TRIG_CTRL, 32'h0);
      cyc(3);
      chk("halt", {31'h0, capt_en}, 32'h0);
      $display("test reset and soft trigger done");
   endtask
   task automatic t_trig();
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_in);
         trig <= act[i] ? 4'h0 : 4'hF;
         wr(OFS_TRIG_CTRL, {24'h0, tcs[i]});
         cyc(6);
         chk("pre", {31'h0, capt_en}, 32'h0);
         @(posedge clk_in);
         trig[pin[i]] <= act[i];
         cyc(6);
         chk("hit", {31'h0, capt_en}, 32'h1);
         wr(OFS_TRIG_CTRL, 32'h0);
         cyc(3);
      end
      $display("test trigger sources done");
   endtask
   task automatic t_mask();
      wr(OFS_AND_MASK, 32'h3FF);
      rchk("mask", OFS_AND_MASK, 32'h3FF);
      wr(OFS_MEM_DATA, 32'hABCDEF);
      @(negedge clk_in);
      chk("memw", {7'h0, mem_wr_out, mem_wdata_out}, 32'h10001EF);
      rchk("memr", OFS_MEM_DATA, 32'h56);
      wr(OFS_TRIG_CTRL, 32'h20);
      rchk("memr meas", OFS_MEM_DATA, 32'h56);
      wr(OFS_TRIG_CTRL, 32'h0);
      wr(OFS_AND_MASK, 32'hFFFFFF);
      $display("test and mask done");
   endtask
   task automatic t_cfg();
      wr(OFS_DELAY_CAPT, 32'h0);
      wr(OFS_DELAY_STIM, 32'h732);
      wr(OFS_DELAY_DUT, 32'h1388);
      cyc(1);
      chk("dcapt", {21'h0, d_capt}, 32'h0);
      chk("dstim", {21'h0, d_stim}, 32'h732);
      chk("ddut", {21'h0, d_dut}, 32'h732);
      wr(OFS_SERIAL_BITS, 32'h18);
      rchk("bits max", OFS_SERIAL_BITS, 32'h18);
      wr(OFS_SERIAL_BITS, 32'h19);
      rchk("bits clamp", OFS_SERIAL_BITS, 32'h18);
      wr(OFS_SERIAL_BITS, 32'h0);
      rchk("bits min", OFS_SERIAL_BITS, 32'h1);
      $display("test delays and bits done");
   endtask
   task automatic t_dio();
      wr(OFS_DIRECT_IO, 32'h5A5A5A);
      cyc(1);
      chk("held", {8'h0, dio_out}, 32'h0);
      rchk("pins", OFS_DIRECT_IO, {8'h0, word});
      wr(OFS_IO_MODE, 32'h5);
      wr(OFS_DIRECT_IO, 32'h5A5A5A);
      cyc(1);
      chk("drive", {8'h0, dio_oe_out}, 32'hFFFFFF);
      chk("out", {8'h0, dio_out}, 32'h5A5A5A);
      rchk("last", OFS_DIRECT_IO, 32'h5A5A5A);
      wr(OFS_IO_MODE, 32'h9);
      wr(OFS_TRIG_CTRL, 32'h20);
      cyc(1);
      chk("split", {8'h0, dio_oe_out}, 32'h0);
      wr(OFS_TRIG_CTRL, 32'h0);
      wr(OFS_IO_MODE, 32'h0);
      cyc(1);
      chk("release", {8'h0, dio_oe_out}, 32'h0);
      $display("test direct io done");
   endtask
   task automatic t_run();
      wr(OFS_SERIAL_BITS, 32'h5);
      wr(OFS_AND_MASK, 32'hFF0F);
      for (int m = 0; m < 5; m++) begin
         wr(OFS_IO_MODE, {28'h0, 3'(m), 1'b0});
         wr(OFS_TRIG_CTRL, 32'h20);
         wr(OFS_SOFT_TRIG, 32'h1);
         cyc(60);
         wr(OFS_TRIG_CTRL, 32'h0);
         cyc(4);
         rchk("sample", OFS_SAMPLE, smp[m]);
      end
      $display("test data modes done");
   endtask
   // ==========================================================
   // verdict and sequence
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_reset();
      t_trig();
      t_mask();
      t_cfg();
      t_dio();
      t_run();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_in);
      fails++;
      print_verdict();
   end
endmodule // ditd_core_tb_top
bind ditd_core ditd_core_chk #(.DATA_W(DATA_W)) i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .capt_clk_en_out(capt_clk_en_out),
   .stim_clk_en_out(stim_clk_en_out), .delay_stim_out(delay_stim_out),
   .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
   .dio_out(dio_out), .dio_oe_out(dio_oe_out));
`default_nettype wire
